// ---- inc/accr_pkg.sv ----
// constants and types for the channel configuration register slice
// assumes a 32-bit APB master; register indices are word indices
package accr_pkg;

  // register word indices; the byte address is four times the index
  localparam logic [5:0] IDX_SPAN_CH7_CH8 = 6'h06;
  localparam logic [5:0] IDX_AVERAGING    = 6'h08;
  localparam logic [5:0] IDX_CAL_CHAN1    = 6'h09;
  localparam logic [5:0] IDX_CAL_CHAN2    = 6'h0A;
  localparam logic [5:0] IDX_CAL_CHAN3    = 6'h0B;
  localparam logic [5:0] IDX_STATUS       = 6'h1F;

  // values after reset
  localparam logic [7:0] RST_SPAN_CH7_CH8 = 8'h33;
  localparam logic [3:0] RST_SPAN_SEL     = 4'h3;
  localparam logic [3:0] RST_AVG_RATIO    = 4'h0;
  localparam logic [3:0] RST_AVG_PAD      = 4'h0;
  localparam logic [5:0] RST_CAL          = 6'h00;
  localparam logic [7:0] RST_EDGE_COUNT   = 8'h00;

  // field positions and widths
  localparam int unsigned SPAN_W        = 4;
  localparam int unsigned SPAN_CH8_LSB  = 4;
  localparam int unsigned SPAN_CH7_LSB  = 0;
  localparam int unsigned AVG_PAD_LSB   = 4;
  localparam int unsigned AVG_RATIO_LSB = 0;
  localparam int unsigned AVG_FIELD_W   = 4;
  localparam int unsigned CAL_W         = 6;
  localparam int unsigned CAL_CHANNELS  = 3;
  localparam int unsigned CAL_STEP_LOG2 = 10;
  localparam int unsigned CAL_OHMS_W    = 17;

  // status register layout
  localparam int unsigned ST_CH7_SPAN_LSB = 0;
  localparam int unsigned ST_CH8_SPAN_LSB = 2;
  localparam int unsigned ST_AVG_EN_BIT   = 4;
  localparam int unsigned ST_CONV_LVL_BIT = 5;
  localparam int unsigned ST_EDGES_LSB    = 8;

  // span selector codes
  localparam logic [3:0] SPAN_CODE_2V5      = 4'h0;
  localparam logic [3:0] SPAN_CODE_5V       = 4'h1;
  localparam logic [3:0] SPAN_CODE_10V_LAST = 4'hB;

  // highest averaging ratio code that still averages
  localparam logic [3:0] AVG_RATIO_CODE_MAX = 4'h8;

  // input pin synchroniser depth
  localparam int unsigned SYNC_STAGES = 3;

  typedef enum logic [1:0]
  {
    span_2v5,
    span_5v,
    span_10v,
    span_undefined
  } accr_span_t;

endpackage

// ---- logic/accr_span_decode.sv ----
// decodes one 4-bit span selector into the front-end span setting
// assumes the selector comes from a register on the same clock
module accr_span_decode
  import accr_pkg::*;
(
  // clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // selector in, decoded span out
  input  wire logic [SPAN_W-1:0] span_sel,
  output accr_span_t             span
);

  accr_span_t next_span;

  always_comb
  begin
    if (span_sel == SPAN_CODE_2V5)
      next_span = span_2v5;
    else if (span_sel == SPAN_CODE_5V)
      next_span = span_5v;
    else if (span_sel <= SPAN_CODE_10V_LAST)
      next_span = span_10v;
    else
      // no span is defined for these codes; front end must not use it
      next_span = span_undefined;
  end

  // reset matches selector reset code 0x3, a 10 V span
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      span <= span_10v;
    else
      span <= next_span;
  end

endmodule

// ---- logic/accr_regs.sv ----
// channel span, averaging and filter calibration registers on APB
// assumes a 32-bit APB master on pclk; conversion_start is a pin
// Summary of operation
// - channel 8 span selector, read/write bits [7:4], resets to 0x3.
// - channel 7 span selector, read/write bits [3:0], resets to 0x3.
// - span code 0000 sets the channel to a +/-2.5 V single-ended span.
// - span code 0001 sets the channel to a +/-5 V single-ended span.
// - span codes 0010 to 1011 set the channel to a +/-10 V single-ended span.
// - averaging ratio [3:0] resets 0; codes 0..8 give 1..256, higher is off.
// - padding in bits [7:4] resets to 0 and lengthens the averaging period.
// - channels 1 to 3 hold a 6-bit filter resistor code, 1024 ohm a step.
module accr_regs
  import accr_pkg::*;
#(
  parameter int unsigned ADDR_W = 8
)
(
  // clock and reset
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  // apb slave
  input  wire logic [ADDR_W-1:0]     paddr,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [31:0]           pwdata,
  input  wire logic [3:0]            pstrb,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  // conversion start pin
  input  wire logic                  conversion_start,
  // front end span settings
  output logic      [SPAN_W-1:0]     chan7_span_sel,
  output logic      [SPAN_W-1:0]     chan8_span_sel,
  output accr_span_t                 chan7_span,
  output accr_span_t                 chan8_span,
  // averaging filter settings
  output logic      [AVG_FIELD_W-1:0] averaging_ratio,
  output logic      [AVG_FIELD_W-1:0] averaging_padding,
  output logic                       averaging_enable,
  output logic      [8:0]            averaging_factor,
  output logic      [9:0]            averaging_period_slots,
  // calibration datapath settings
  output logic      [CAL_W-1:0]      chan1_filter_res_cal,
  output logic      [CAL_W-1:0]      chan2_filter_res_cal,
  output logic      [CAL_W-1:0]      chan3_filter_res_cal,
  output logic      [CAL_OHMS_W-1:0] chan1_series_filter_resistor,
  output logic      [CAL_OHMS_W-1:0] chan2_series_filter_resistor,
  output logic      [CAL_OHMS_W-1:0] chan3_series_filter_resistor
);

  // storage
  logic [SPAN_W-1:0]      span_ch7;
  logic [SPAN_W-1:0]      span_ch8;
  logic [AVG_FIELD_W-1:0] avg_ratio;
  logic [AVG_FIELD_W-1:0] avg_pad;
  logic [CAL_W-1:0]       cal [CAL_CHANNELS];
  logic [7:0]             edge_count;

  // conversion start synchroniser
  logic [SYNC_STAGES-1:0] conv_sync;
  logic                   conv_level;

  // apb decode
  wire  [5:0]  word_idx;
  wire         setup_phase;
  wire         access_phase;
  wire         wr_take;
  wire         lane0;
  wire         hit_span;
  wire         hit_avg;
  wire         hit_status;
  wire  [2:0]  hit_cal;
  wire         mapped;
  wire  [7:0]  rd_mux;
  wire  [31:0] status_word;
  wire         conv_agree;
  wire         conv_rise;

  assign word_idx     = paddr[7:2];
  assign setup_phase  = psel & ~penable;
  assign access_phase = psel & penable;
  // always ready: every register answers with no wait state
  assign pready       = 1'b1;
  assign wr_take      = access_phase & pready & pwrite & ~pslverr;
  // writable registers are one byte wide, so only byte lane 0 carries data
  assign lane0        = pstrb[0];

  assign hit_span   = (word_idx == IDX_SPAN_CH7_CH8);
  assign hit_avg    = (word_idx == IDX_AVERAGING);
  assign hit_status = (word_idx == IDX_STATUS);
  assign hit_cal[0] = (word_idx == IDX_CAL_CHAN1);
  assign hit_cal[1] = (word_idx == IDX_CAL_CHAN2);
  assign hit_cal[2] = (word_idx == IDX_CAL_CHAN3);
  assign mapped     = hit_span | hit_avg | hit_status | (|hit_cal);

  // reserved calibration bits always return zero
  assign rd_mux =
    hit_span   ? {span_ch8, span_ch7} :
    hit_avg    ? {avg_pad, avg_ratio} :
    hit_cal[0] ? {2'b00, cal[0]} :
    hit_cal[1] ? {2'b00, cal[1]} :
    hit_cal[2] ? {2'b00, cal[2]} :
    8'h00;

  assign status_word =
    {16'h0000, edge_count, 2'b00, conv_level, averaging_enable,
     chan8_span, chan7_span};

  // read data is latched in setup so the access phase sees a flop
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0000_0000;
    else if (setup_phase && !pwrite)
      prdata <= hit_status ? status_word : {24'h00_0000, rd_mux};
  end

  // unmapped word answers with an error in its access phase
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pslverr <= 1'b0;
    else
      pslverr <= setup_phase & ~mapped;
  end

  // span selectors for channels 7 and 8
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      span_ch8 <= RST_SPAN_CH7_CH8[SPAN_CH8_LSB +: SPAN_W];
      span_ch7 <= RST_SPAN_CH7_CH8[SPAN_CH7_LSB +: SPAN_W];
    end
    else if (wr_take && hit_span && lane0)
    begin
      span_ch8 <= pwdata[SPAN_CH8_LSB +: SPAN_W];
      span_ch7 <= pwdata[SPAN_CH7_LSB +: SPAN_W];
    end
  end

  // averaging ratio and padding
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      avg_ratio <= RST_AVG_RATIO;
      avg_pad   <= RST_AVG_PAD;
    end
    else if (wr_take && hit_avg && lane0)
    begin
      avg_ratio <= pwdata[AVG_RATIO_LSB +: AVG_FIELD_W];
      avg_pad   <= pwdata[AVG_PAD_LSB +: AVG_FIELD_W];
    end
  end

  // calibration storage, one entry per channel
  genvar g;
  generate
    for (g = 0; g < CAL_CHANNELS; g++)
    begin : g_cal
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
          cal[g] <= RST_CAL;
        else if (wr_take && hit_cal[g] && lane0)
          // upper two bits of the byte are dropped here
          cal[g] <= pwdata[CAL_W-1:0];
      end
    end
  endgenerate

  // conversion start: three flops, level moves when stages 2 and 3 agree
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      conv_sync <= '0;
    else
      conv_sync <= {conv_sync[SYNC_STAGES-2:0], conversion_start};
  end

  assign conv_agree = (conv_sync[1] == conv_sync[2]);
  assign conv_rise  = conv_agree & conv_sync[2] & ~conv_level;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      conv_level <= 1'b0;
    else if (conv_agree)
      conv_level <= conv_sync[2];
  end

  // counts conversion start edges so software can see the core pacing
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      edge_count <= RST_EDGE_COUNT;
    else if (conv_rise)
      edge_count <= edge_count + 8'h01;
  end

  // span decoders
  accr_span_decode u_span_ch7
  (
    .pclk     (pclk),
    .presetn  (presetn),
    .span_sel (span_ch7),
    .span     (chan7_span)
  );

  accr_span_decode u_span_ch8
  (
    .pclk     (pclk),
    .presetn  (presetn),
    .span_sel (span_ch8),
    .span     (chan8_span)
  );

  // averaging: codes above the top ratio code switch it off
  assign averaging_enable = (avg_ratio != 4'h0)
                          & (avg_ratio <= AVG_RATIO_CODE_MAX);
  assign averaging_factor = (avg_ratio <= AVG_RATIO_CODE_MAX)
                          ? (9'h001 << avg_ratio)
                          : 9'h001;
  // padding adds idle slots so samples spread evenly between starts
  assign averaging_period_slots = averaging_enable
                          ? ({1'b0, averaging_factor}
                             + {6'h00, avg_pad})
                          : 10'h001;

  assign averaging_ratio   = avg_ratio;
  assign averaging_padding = avg_pad;
  assign chan7_span_sel    = span_ch7;
  assign chan8_span_sel    = span_ch8;

  assign chan1_filter_res_cal = cal[0];
  assign chan2_filter_res_cal = cal[1];
  assign chan3_filter_res_cal = cal[2];

  // code times 1024 ohm
  assign chan1_series_filter_resistor =
    {1'b0, cal[0], {CAL_STEP_LOG2{1'b0}}};
  assign chan2_series_filter_resistor =
    {1'b0, cal[1], {CAL_STEP_LOG2{1'b0}}};
  assign chan3_series_filter_resistor =
    {1'b0, cal[2], {CAL_STEP_LOG2{1'b0}}};

endmodule

// ---- test/accr_regs_chk.sv ----
// assertions for the channel configuration register slice
// assumes binding onto accr_regs; sees its ports only
module accr_regs_chk
  import accr_pkg::*;
#(
  parameter int unsigned ADDR_W = 8
)
(
  // clock, reset and apb
  input wire logic                  pclk,
  input wire logic                  presetn,
  input wire logic [ADDR_W-1:0]     paddr,
  input wire logic                  psel,
  input wire logic                  penable,
  input wire logic                  pwrite,
  input wire logic [31:0]           pwdata,
  input wire logic [3:0]            pstrb,
  input wire logic [31:0]           prdata,
  // settings
  input wire logic [SPAN_W-1:0]     chan7_span_sel,
  input wire logic [SPAN_W-1:0]     chan8_span_sel,
  input wire accr_span_t            chan7_span,
  input wire accr_span_t            chan8_span,
  input wire logic [AVG_FIELD_W-1:0] averaging_ratio,
  input wire logic [AVG_FIELD_W-1:0] averaging_padding,
  input wire logic [8:0]            averaging_factor,
  input wire logic [CAL_W-1:0]      chan1_filter_res_cal,
  input wire logic [CAL_OHMS_W-1:0] chan1_series_filter_resistor
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence wr_to(logic [5:0] idx);
    psel && penable && pwrite && pstrb[0] && paddr[7:2] == idx;
  endsequence
  sequence rd_to(logic [5:0] idx);
    psel && penable && !pwrite && paddr[7:2] == idx;
  endsequence

  a_ch8_sel_wr: assert property (wr_to(IDX_SPAN_CH7_CH8) |=>
    chan8_span_sel == $past(pwdata[7:4])) else $error("ch8 span lost");
  a_ch7_sel_wr: assert property (wr_to(IDX_SPAN_CH7_CH8) |=>
    chan7_span_sel == $past(pwdata[3:0])) else $error("ch7 span lost");
  a_span_2v5: assert property (chan7_span_sel == SPAN_CODE_2V5 |=>
    chan7_span == span_2v5) else $error("code 0 not 2.5 V");
  a_span_5v: assert property (chan8_span_sel == SPAN_CODE_5V |=>
    chan8_span == span_5v) else $error("code 1 not 5 V");
  a_span_10v: assert property (chan7_span_sel >= 4'h2 &&
    chan7_span_sel <= SPAN_CODE_10V_LAST |=> chan7_span == span_10v)
    else $error("code 2..11 not 10 V");
  a_ratio_factor: assert property ($stable(averaging_ratio) &&
    averaging_ratio <= AVG_RATIO_CODE_MAX |->
    averaging_factor == 9'(1) << averaging_ratio)
    else $error("averaging factor wrong");
  a_pad_wr: assert property (wr_to(IDX_AVERAGING) |=>
    averaging_padding == $past(pwdata[7:4])) else $error("padding lost");
  a_cal_wr: assert property (wr_to(IDX_CAL_CHAN1) |=>
    chan1_filter_res_cal == $past(pwdata[5:0])) else $error("cal lost");
  a_cal_ohms: assert property (chan1_series_filter_resistor ==
    17'(chan1_filter_res_cal) << 10) else $error("cal ohms wrong");
  a_cal_top_zero: assert property (rd_to(IDX_CAL_CHAN1) |->
    prdata[7:6] == 2'b00) else $error("cal top bits not zero");
endmodule

bind accr_regs accr_regs_chk #(.ADDR_W(ADDR_W)) u_chk (.pclk, .presetn,
  .paddr, .psel, .penable, .pwrite, .pwdata, .pstrb, .prdata,
  .chan7_span_sel, .chan8_span_sel, .chan7_span, .chan8_span,
  .averaging_ratio, .averaging_padding, .averaging_factor,
  .chan1_filter_res_cal, .chan1_series_filter_resistor);

// ---- test/testbench.sv ----
// self-checking bench for the channel configuration register slice
// assumes accr_pkg compiled first; checker is bound from its own file
`define CHK(nm, exp, got) \
  begin \
    num_checks++; \
    if ((got) !== (exp)) \
    begin \
      bad_count++; \
      $display("Error %s expected %h seen %h", nm, exp, got); \
    end \
  end
module testbench
  import accr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic        conversion_start = 0;
  logic [7:0]  paddr = 0;
  logic [31:0] pwdata = 0;
  logic [3:0]  pstrb = 0;
  wire  [31:0] prdata;
  wire         pready, pslverr;
  wire  [9:0]  slots;
  wire  [5:0]  cal_code [3];
  wire  [16:0] ohms [3];
  logic [32:0] exp_q[$];
  logic [32:0] e;
  int          bad_count = 0, num_checks = 0;
  integer      seed = 32'h692BAADB;

  always #50 pclk = ~pclk;

  accr_regs dut (.pclk, .presetn, .paddr, .psel, .penable, .pwrite,
    .pwdata, .pstrb, .prdata, .pready, .pslverr, .conversion_start,
    .chan7_span_sel(), .chan8_span_sel(), .chan7_span(), .chan8_span(),
    .averaging_ratio(), .averaging_padding(), .averaging_enable(),
    .averaging_factor(), .averaging_period_slots(slots),
    .chan1_filter_res_cal(cal_code[0]), .chan2_filter_res_cal(cal_code[1]),
    .chan3_filter_res_cal(cal_code[2]),
    .chan1_series_filter_resistor(ohms[0]),
    .chan2_series_filter_resistor(ohms[1]),
    .chan3_series_filter_resistor(ohms[2]));

  task automatic apb(logic [5:0] idx, logic wr, logic [31:0] d,
                     logic [3:0] s);
    @(posedge pclk);
    psel <= 1;
    paddr <= {idx, 2'b00};
    pwrite <= wr;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1;
    // no local limit: only the watchdog ends a stuck wait
    do
    begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    psel <= 0;
    penable <= 0;
  endtask

  task automatic rd(logic [5:0] idx, logic [32:0] x);
    exp_q.push_back(x);
    apb(idx, 0, $random(seed), 4'hF);
  endtask

  task automatic wr(logic [5:0] idx, logic [7:0] d);
    logic [31:0] r = $random(seed);
    apb(idx, 1, {r[31:8], d}, 4'hF);
  endtask

  function automatic logic [32:0] ok(logic [31:0] v);
    return {1'b0, v};
  endfunction

  function automatic logic [1:0] spn(int c);
    return (c == 0) ? 2'd0 : (c == 1) ? 2'd1 : 2'd2;
  endfunction

  task automatic chk_reset();
    rd(IDX_SPAN_CH7_CH8, ok({24'h0, RST_SPAN_CH7_CH8}));
    rd(IDX_AVERAGING, ok({24'h0, RST_AVG_PAD, RST_AVG_RATIO}));
    for (int i = 0; i < 3; i++)
      rd(6'(IDX_CAL_CHAN1 + i), ok(32'h0));
    rd(IDX_STATUS, ok({27'h0, 1'b0, 2'd2, 2'd2}));
    $display("test reset_values done");
  endtask

  // reads finish at the access edge; old values are sampled there
  always @(posedge pclk)
    if (presetn && psel && penable && pready && !pwrite)
    begin
      e = (exp_q.size() > 0) ? exp_q.pop_front() : 'x;
      `CHK("read", e, {pslverr, prdata})
    end

  task automatic end_of_test();
    repeat (2) @(posedge pclk);
    if (exp_q.size() != 0)
      bad_count++;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial
  begin
    repeat (5000) @(posedge pclk);
    bad_count++;
    end_of_test();
  end

  initial
  begin
    logic [7:0] v;
    logic [9:0] es;
    int         n;
    repeat (3) @(posedge pclk);
    presetn <= 1;
    chk_reset();
    for (int c = 0; c < 12; c++)
    begin
      wr(IDX_SPAN_CH7_CH8, {4'(11 - c), 4'(c)}); // codes 0..11 only
      rd(IDX_SPAN_CH7_CH8, ok({24'h0, 4'(11 - c), 4'(c)}));
      rd(IDX_STATUS, ok({28'h0, spn(11 - c), spn(c)}));
    end
    $display("test span_codes done");
    for (int c = 0; c < 16; c++)
    begin
      v = $random(seed);
      v[3:0] = 4'(c);
      wr(IDX_AVERAGING, v);
      rd(IDX_AVERAGING, ok({24'h0, v}));
      rd(IDX_STATUS, ok({27'h0, c >= 1 && c <= 8, 4'h2}));
      es = (c >= 1 && c <= 8) ? 10'(1 << c) + 10'(v[7:4]) : 10'h001;
      `CHK("slots", es, slots)
    end
    $display("test averaging done");
    for (int c = 0; c < 3; c++)
    begin
      v = $random(seed);
      wr(6'(IDX_CAL_CHAN1 + c), v);
      rd(6'(IDX_CAL_CHAN1 + c), ok({26'h0, v[5:0]}));
      `CHK("cal", v[5:0], cal_code[c])
      `CHK("ohms", 17'(v[5:0]) * 17'h00400, ohms[c])
    end
    // low byte strobe off: the write must not land
    apb(IDX_CAL_CHAN3, 1, ~{24'h0, v}, 4'hE);
    rd(IDX_CAL_CHAN3, ok({26'h0, v[5:0]}));
    `CHK("cal3", v[5:0], cal_code[2])
    $display("test calibration done");
    rd(6'h07, {1'b1, 32'h0});
    apb(6'h07, 1, 32'hFF, 4'hF);
    rd(IDX_SPAN_CH7_CH8, ok(32'h0B));
    $display("test unmapped done");
    // pulses well above the two-clock minimum, then a held high level
    n = 1 + ($random(seed) & 3);
    repeat (n)
    begin
      conversion_start <= 1;
      repeat (3) @(posedge pclk);
      conversion_start <= 0;
      repeat (3) @(posedge pclk);
    end
    conversion_start <= 1;
    repeat (4) @(posedge pclk);
    rd(IDX_STATUS, ok({16'h0, 8'(n + 1), 8'h22}));
    conversion_start <= 0;
    repeat (4) @(posedge pclk);
    rd(IDX_STATUS, ok({16'h0, 8'(n + 1), 8'h02}));
    $display("test conversion_start done");
    @(posedge pclk);
    presetn <= 0;
    repeat (2) @(posedge pclk);
    presetn <= 1;
    chk_reset();
    end_of_test();
  end
endmodule
